// File: hw/drive_monitor_pkg.sv
// Constants for the servo drive status and monitor bank
package drive_monitor_pkg;
	localparam logic [15:0] ADDR_SHAFT_VELOCITY = 16'h1D1C;
	localparam logic [15:0] ADDR_POSITION_LOW = 16'h2E2D;
	localparam logic [15:0] ADDR_BUS_VOLTAGE = 16'h3736;
	localparam logic [15:0] ADDR_COMMAND_OUTPUT = 16'h3938;
	localparam logic [15:0] ADDR_TORQUE_CURRENT = 16'h4544;
	localparam logic [15:0] ADDR_FLUX_CURRENT = 16'h4746;
	localparam logic [15:0] ADDR_MULTI_TURN = 16'h5756;
	localparam logic [15:0] ADDR_MOTOR_SENSOR = 16'h8700;
	localparam logic [15:0] ADDR_HEATSINK_TEMP = 16'h8726;
	localparam logic [15:0] ADDR_POSITION_HIGH = 16'h872F;
	localparam logic [15:0] UNMAPPED_READ = 16'h0000;
	// Arbitrary neutral revision and logicware values
	localparam logic [3:0] LOGIC_HW_REVISION = 4'h1;
	localparam logic [7:0] LW_MAJOR = 8'h01;
	localparam logic [7:0] LW_MINOR = 8'h00;
	localparam logic [7:0] LW_SUFFIX = 8'h41;
	localparam logic [4:0] MODEL_CODE_MAX = 5'h06;
	localparam logic [2:0] FB_FAULT_SENSOR = 3'h1;
	localparam logic [2:0] FB_FAULT_MULTI_TURN = 3'h3;
	localparam logic [3:0] ROTARY_MAX = 4'h9;
	localparam logic SOFT_ENABLE_RESET = 1'b1;
	localparam logic HALF_PWM_RESET = 1'b0;
	// Current thresholds in 1/100 of peak, frequencies in 1/100 Hz
	localparam logic [7:0] HALF_ENTER_CURRENT_PCT = 8'h35;
	localparam logic [7:0] HALF_EXIT_CURRENT_PCT = 8'h20;
	localparam logic [15:0] HALF_ENTER_FREQ_CHZ = 16'h0122;
	localparam logic [15:0] HALF_EXIT_FREQ_CHZ = 16'h01DD;
	localparam int VEL_AVG_SAMPLES = 512;
	localparam int VEL_AVG_SHIFT = 9;
	localparam real FILTER_PERIOD_MS = 26.21;
	localparam real CLK_MHZ = 100.0;
	localparam int FILTER_PERIOD_CYC = int'(FILTER_PERIOD_MS * 1000.0 * CLK_MHZ - 0.5);
endpackage : drive_monitor_pkg

// File: hw/drive_status_monitor.sv
// Read-only status and monitor bank of a servo drive, plus a writable soft enable
// How it works
// [RQ1] Report 4-bit wrapping logic hardware revision
// [RQ2] Model code 0-31, unlisted codes flag error
// [RQ3] Single-turn position 24 bits, 8 fractional
// [RQ4] Signed 12-bit instantaneous turn count
// [RQ5] Enter half PWM: high current, low frequency
// [RQ6] Leave half PWM: low current or fast
// [RQ7] Half PWM flag: 0 base, 1 half
// [RQ8] Report rotary switch 0 to 9
// [RQ9] DIP switch 0-15, open reads high
// [RQ10] Feedback fault: 001 sensor, 011 multi-turn
// [RQ11] Flag six-step versus sinusoidal commutation
// [RQ12] Power needs hardware and software enable
// [RQ13] Soft enable up at reset, writable
// [RQ14] Signed raw velocity, 0.5588 rpm per count
// [RQ15] Filtered velocity: position difference per period
// [RQ16] Logicware version as three bytes
// [RQ17] Motor sensor resistance in ohms
// [RQ18] Instantaneous bus voltage sample
// [RQ19] Position split low word, high byte
// [RQ20] Drive healthy flag inverts fault output
// [RQ21] Monitor reads have no side effects
`timescale 1ns/1ps
module drive_status_monitor
	import drive_monitor_pkg::*;
(
	input wire logic i_ref_clk,
	input wire logic i_rst,
	input wire logic [4:0] i_model_code,
	input wire logic [23:0] i_position,
	input wire logic [11:0] i_turn_count,
	input wire logic [15:0] i_raw_velocity,
	input wire logic [15:0] i_bus_voltage,
	input wire logic [19:0] i_motor_sensor_ohms,
	input wire logic [15:0] i_command_output,
	input wire logic [15:0] i_torque_current,
	input wire logic [15:0] i_flux_current,
	input wire logic [15:0] i_heatsink_temp,
	input wire logic [7:0] i_current_pct,
	input wire logic [15:0] i_commutation_freq_chz,
	input wire logic [3:0] i_rotary_switch,
	input wire logic [3:0] i_dip_switch_closed,
	input wire logic [2:0] i_feedback_fault_code,
	input wire logic i_six_step,
	input wire logic i_hw_enable,
	input wire logic i_soft_enable_we,
	input wire logic i_soft_enable_wdata,
	input wire logic i_drive_fault,
	input wire logic i_mon_rd,
	input wire logic [15:0] i_mon_addr,
	output logic [15:0] o_mon_data,
	output logic o_mon_valid,
	output logic [3:0] o_logic_hw_revision,
	output logic [23:0] o_logicware_version,
	output logic o_config_error,
	output logic [23:0] o_single_turn_position,
	output logic [11:0] o_turn_count,
	output logic [15:0] o_raw_velocity,
	output logic [15:0] o_filtered_velocity,
	output logic [15:0] o_bus_voltage,
	output logic [19:0] o_motor_sensor_ohms,
	output logic o_half_pwm_flag,
	output logic [3:0] o_rotary_switch_value,
	output logic o_rotary_invalid,
	output logic [3:0] o_dip_switch_value,
	output logic o_fault_sensor,
	output logic o_fault_multi_turn,
	output logic o_commutation_mode_flag,
	output logic o_soft_power_enable,
	output logic o_power_enable,
	output logic o_drive_healthy_flag
);
	logic soft_en_q;
	logic half_q;
	logic [23:0] prev_pos_q;
	logic [31:0] period_cnt_q;
	logic [23:0] pos_diff;
	logic model_ok;

	function automatic logic model_valid(input logic [4:0] code);
		model_valid = (code <= MODEL_CODE_MAX);
	endfunction : model_valid

	assign model_ok = model_valid(i_model_code);
	assign pos_diff = i_position - prev_pos_q;

	// Software enable, set at power-up
	always_ff @(posedge i_ref_clk or posedge i_rst)
	begin
		if (i_rst)
			soft_en_q <= SOFT_ENABLE_RESET; // [RQ13]
		else if (i_soft_enable_we)
			soft_en_q <= i_soft_enable_wdata; // [RQ13]
	end

	// Hysteresis keeps the PWM rate from chattering near one threshold
	always_ff @(posedge i_ref_clk or posedge i_rst)
	begin
		if (i_rst)
			half_q <= HALF_PWM_RESET;
		else if (!half_q && i_current_pct > HALF_ENTER_CURRENT_PCT
			&& i_commutation_freq_chz < HALF_ENTER_FREQ_CHZ)
			half_q <= 1'b1; // [RQ5]
		else if (half_q && (i_current_pct < HALF_EXIT_CURRENT_PCT
			|| i_commutation_freq_chz > HALF_EXIT_FREQ_CHZ))
			half_q <= 1'b0; // [RQ6]
	end

	// Position differenced over the filter period equals a 512-sample mean
	always_ff @(posedge i_ref_clk or posedge i_rst)
	begin
		if (i_rst)
		begin
			period_cnt_q <= 32'h00000000;
			prev_pos_q <= 24'h000000;
			o_filtered_velocity <= 16'h0000;
		end
		else if (period_cnt_q == 32'(FILTER_PERIOD_CYC - 1))
		begin
			period_cnt_q <= 32'h00000000;
			prev_pos_q <= i_position; // [RQ15]
			o_filtered_velocity <= pos_diff[23:8]; // [RQ15]
		end
		else
			period_cnt_q <= period_cnt_q + 32'h00000001;
	end

	// Sampled status
	always_ff @(posedge i_ref_clk or posedge i_rst)
	begin
		if (i_rst)
		begin
			o_logic_hw_revision <= 4'h0;
			o_logicware_version <= 24'h000000;
			o_config_error <= 1'b0;
			o_single_turn_position <= 24'h000000;
			o_turn_count <= 12'h000;
			o_raw_velocity <= 16'h0000;
			o_bus_voltage <= 16'h0000;
			o_motor_sensor_ohms <= 20'h00000;
			o_half_pwm_flag <= 1'b0;
			o_rotary_switch_value <= 4'h0;
			o_rotary_invalid <= 1'b0;
			o_dip_switch_value <= 4'h0;
			o_fault_sensor <= 1'b0;
			o_fault_multi_turn <= 1'b0;
			o_commutation_mode_flag <= 1'b0;
			o_soft_power_enable <= SOFT_ENABLE_RESET;
			o_power_enable <= 1'b0;
			o_drive_healthy_flag <= 1'b0;
		end
		else
		begin
			o_logic_hw_revision <= LOGIC_HW_REVISION; // [RQ1]
			o_logicware_version <= {LW_MAJOR, LW_MINOR, LW_SUFFIX}; // [RQ16]
			o_config_error <= !model_ok; // [RQ2]
			o_single_turn_position <= i_position; // [RQ3]
			o_turn_count <= i_turn_count; // [RQ4]
			o_raw_velocity <= i_raw_velocity; // [RQ14]
			o_bus_voltage <= i_bus_voltage; // [RQ18]
			o_motor_sensor_ohms <= i_motor_sensor_ohms; // [RQ17]
			o_half_pwm_flag <= half_q; // [RQ7]
			o_rotary_switch_value <= i_rotary_switch; // [RQ8]
			o_rotary_invalid <= i_rotary_switch > ROTARY_MAX; // [RQ8]
			o_dip_switch_value <= ~i_dip_switch_closed; // [RQ9]
			o_fault_sensor <= i_feedback_fault_code == FB_FAULT_SENSOR; // [RQ10]
			o_fault_multi_turn <= i_feedback_fault_code == FB_FAULT_MULTI_TURN; // [RQ10]
			o_commutation_mode_flag <= i_six_step; // [RQ11]
			o_soft_power_enable <= soft_en_q;
			o_power_enable <= i_hw_enable && soft_en_q; // [RQ12]
			o_drive_healthy_flag <= !i_drive_fault; // [RQ20]
		end
	end

	// Monitor read port; reads only select, never alter state
	always_ff @(posedge i_ref_clk or posedge i_rst)
	begin
		if (i_rst)
		begin
			o_mon_data <= 16'h0000;
			o_mon_valid <= 1'b0;
		end
		else
		begin
			o_mon_valid <= i_mon_rd; // [RQ21]
			if (i_mon_rd)
			begin
				unique case (i_mon_addr)
					ADDR_SHAFT_VELOCITY: o_mon_data <= i_raw_velocity;
					ADDR_POSITION_LOW: o_mon_data <= i_position[15:0]; // [RQ19]
					ADDR_POSITION_HIGH: o_mon_data <= {8'h00, i_position[23:16]}; // [RQ19]
					ADDR_BUS_VOLTAGE: o_mon_data <= i_bus_voltage;
					ADDR_COMMAND_OUTPUT: o_mon_data <= i_command_output;
					ADDR_TORQUE_CURRENT: o_mon_data <= i_torque_current;
					ADDR_FLUX_CURRENT: o_mon_data <= i_flux_current;
					ADDR_MULTI_TURN: o_mon_data <= {{4{i_turn_count[11]}}, i_turn_count};
					// Wide resistance saturates in a 16-bit slot
					ADDR_MOTOR_SENSOR: o_mon_data <= (|i_motor_sensor_ohms[19:16])
						? 16'hFFFF : i_motor_sensor_ohms[15:0];
					ADDR_HEATSINK_TEMP: o_mon_data <= i_heatsink_temp;
					default: o_mon_data <= UNMAPPED_READ;
				endcase
			end
		end
	end

	a_power_gate: assert property (@(posedge i_ref_clk) disable iff (i_rst)
		o_power_enable |-> $past(i_hw_enable) && $past(soft_en_q)) // [RQ12]
		else $error("power enabled without both enables");
	a_soft_write: assert property (@(posedge i_ref_clk) disable iff (i_rst)
		i_soft_enable_we && !i_soft_enable_wdata |=> ##1 !o_soft_power_enable) // [RQ13]
		else $error("soft disable not seen");
	a_half_enter: assert property (@(posedge i_ref_clk) disable iff (i_rst)
		!half_q && i_current_pct > HALF_ENTER_CURRENT_PCT
		&& i_commutation_freq_chz < HALF_ENTER_FREQ_CHZ |=> half_q) // [RQ5]
		else $error("half pwm not entered");
	a_half_exit: assert property (@(posedge i_ref_clk) disable iff (i_rst)
		half_q && i_current_pct < HALF_EXIT_CURRENT_PCT |=> !half_q) // [RQ6]
		else $error("half pwm not left");
	a_half_flag: assert property (@(posedge i_ref_clk) disable iff (i_rst)
		$rose(half_q) |=> o_half_pwm_flag) // [RQ7]
		else $error("half flag lags");
	a_healthy_inv: assert property (@(posedge i_ref_clk) disable iff (i_rst)
		i_drive_fault |=> !o_drive_healthy_flag) // [RQ20]
		else $error("healthy flag during fault");
	a_dip_polarity: assert property (@(posedge i_ref_clk) disable iff (i_rst)
		i_dip_switch_closed == 4'hF |=> o_dip_switch_value == 4'h0) // [RQ9]
		else $error("dip polarity wrong");
	a_fault_decode: assert property (@(posedge i_ref_clk) disable iff (i_rst)
		i_feedback_fault_code == 3'h2 |=> !o_fault_sensor && !o_fault_multi_turn) // [RQ10]
		else $error("fault decode wrong");
	a_pos_high: assert property (@(posedge i_ref_clk) disable iff (i_rst)
		i_mon_rd && i_mon_addr == ADDR_POSITION_HIGH
		|=> o_mon_valid && o_mon_data[7:0] == $past(i_position[23:16])) // [RQ19]
		else $error("position high byte wrong");
	a_config_err: assert property (@(posedge i_ref_clk) disable iff (i_rst)
		i_model_code > MODEL_CODE_MAX |=> o_config_error) // [RQ2]
		else $error("bad model not flagged");
endmodule : drive_status_monitor

// File: bench/mon_reader.sv
// Monitor reader standing in for the networked motion controller
`timescale 1ns/1ps
module mon_reader
(
	input wire logic i_ref_clk,
	input wire logic i_rst,
	input wire logic i_req,
	input wire logic [15:0] i_addr,
	input wire logic i_mon_valid,
	input wire logic [15:0] i_mon_data,
	output logic o_mon_rd,
	output logic [15:0] o_mon_addr,
	output logic [15:0] o_data,
	output logic o_done
);
	// Idle address toggles so a stale address never looks held
	always_ff @(posedge i_ref_clk or posedge i_rst)
		if (i_rst)
			{o_mon_rd, o_mon_addr, o_data, o_done} <= '0;
		else
		begin
			o_mon_rd <= i_req;
			o_mon_addr <= i_req ? i_addr : ~o_mon_addr;
			o_done <= i_mon_valid;
			if (i_mon_valid)
				o_data <= i_mon_data;
		end
endmodule : mon_reader

// File: bench/servo_drive_status_monitor_tb.sv
// Self-checking bench for the drive status and monitor bank
`timescale 1ns/1ps
module servo_drive_status_monitor_tb;
	import drive_monitor_pkg::*;
	logic clk = 0, rst = 1, req = 0, six = 0, hwen = 1, swe = 0, swd = 0, flt = 0;
	logic [15:0] addr = '0, vel = '0, bus_voltage_sample = '0, cmd = '0, tq = '0, fx = '0, hs = '0;
	logic [15:0] freq = '0, rdat, mdata, maddr, fvel, ovel, ovbus;
	logic [23:0] pos = '0, lwv, opos;
	logic [19:0] ohms = '0, oohm;
	logic [11:0] turns = '0, oturn;
	logic [7:0] cur = '0;
	logic [4:0] model = '0;
	logic [3:0] rot = '0, dip = '0, orot, odip, orev;
	logic [2:0] ff = '0;
	logic mrd, mval, done, cerr, half, rinv, fs, fm, cmf, spe, pwr, ok;
	int miscompares = 0, samples_checked = 0, cycles = 0;
	drive_status_monitor dut (.i_ref_clk(clk), .i_rst(rst), .i_model_code(model),
		.i_position(pos), .i_turn_count(turns), .i_raw_velocity(vel), .i_bus_voltage(bus_voltage_sample),
		.i_motor_sensor_ohms(ohms), .i_command_output(cmd), .i_torque_current(tq),
		.i_flux_current(fx), .i_heatsink_temp(hs), .i_current_pct(cur),
		.i_commutation_freq_chz(freq), .i_rotary_switch(rot), .i_dip_switch_closed(dip),
		.i_feedback_fault_code(ff), .i_six_step(six), .i_hw_enable(hwen),
		.i_soft_enable_we(swe), .i_soft_enable_wdata(swd), .i_drive_fault(flt),
		.i_mon_rd(mrd), .i_mon_addr(maddr), .o_mon_data(mdata), .o_mon_valid(mval),
		.o_logic_hw_revision(orev), .o_logicware_version(lwv), .o_config_error(cerr),
		.o_single_turn_position(opos), .o_turn_count(oturn), .o_raw_velocity(ovel),
		.o_filtered_velocity(fvel), .o_bus_voltage(ovbus), .o_motor_sensor_ohms(oohm),
		.o_half_pwm_flag(half), .o_rotary_switch_value(orot), .o_rotary_invalid(rinv),
		.o_dip_switch_value(odip), .o_fault_sensor(fs), .o_fault_multi_turn(fm),
		.o_commutation_mode_flag(cmf), .o_soft_power_enable(spe), .o_power_enable(pwr),
		.o_drive_healthy_flag(ok));
	mon_reader reader (.i_ref_clk(clk), .i_rst(rst), .i_req(req), .i_addr(addr),
		.i_mon_valid(mval), .i_mon_data(mdata), .o_mon_rd(mrd), .o_mon_addr(maddr),
		.o_data(rdat), .o_done(done));
	initial
		forever #5 clk = ~clk;
	always @(posedge clk)
	begin
		cycles++;
		if (cycles == 20000)
		begin
			miscompares++;
			complete_run();
		end
	end
	task automatic chk(input string what, input logic [23:0] exp, input logic [23:0] got);
		samples_checked++;
		if (got !== exp)
		begin
			$display("FAIL %s expected %h seen %h", what, exp, got);
			miscompares++;
		end
	endtask : chk
	task automatic settle();
		repeat (3) @(posedge clk);
		@(negedge clk);
	endtask : settle
	// Reader handshake; the answer is bounded so a silent bank cannot hang us
	task automatic rd(input logic [15:0] a);
		@(posedge clk);
		req <= 1'b1;
		addr <= a;
		@(posedge clk);
		req <= 1'b0;
		repeat (8)
		begin
			@(negedge clk);
			if (done === 1'b1)
				break;
		end
		chk("read answer", 24'h1, {23'h0, done});
	endtask : rd
	task automatic test_reads();
		logic [15:0] ad [11] = '{ADDR_SHAFT_VELOCITY, ADDR_POSITION_LOW, ADDR_BUS_VOLTAGE,
			ADDR_COMMAND_OUTPUT, ADDR_TORQUE_CURRENT, ADDR_FLUX_CURRENT, ADDR_MULTI_TURN,
			ADDR_MOTOR_SENSOR, ADDR_HEATSINK_TEMP, ADDR_POSITION_HIGH, 16'h0000};
		logic [15:0] ex [11] = '{16'hB7A4, 16'hC3E1, 16'h020B, 16'h1234, 16'h8001,
			16'h7FFE, 16'hF800, 16'hFFFF, 16'h0055, 16'h00A5, 16'h0000};
		logic [15:0] lo;
		@(posedge clk);
		{vel, pos, bus_voltage_sample, cmd, tq} <= {16'hB7A4, 24'hA5C3E1, 16'h020B, 16'h1234, 16'h8001};
		{fx, turns, ohms, hs} <= {16'h7FFE, 12'h800, 20'hD3266, 16'h0055};
		settle();
		for (int k = 0; k < 11; k++)
		begin
			rd(ad[k]);
			chk("monitor word", {8'h0, ex[k]}, {8'h0, rdat});
		end
		rd(ADDR_POSITION_LOW);
		lo = rdat;
		rd(ADDR_POSITION_HIGH);
		chk("joined position", 24'hA5C3E1, {rdat[7:0], lo});
		chk("position", 24'hA5C3E1, opos);
		chk("turns", 24'h800, {12'h0, oturn});
		chk("raw velocity", 24'hB7A4, {8'h0, ovel});
		chk("bus voltage", 24'h20B, {8'h0, ovbus});
		chk("sensor ohms", 24'hD3266, {4'h0, oohm});
		$display("test reads done");
	endtask : test_reads
	task automatic test_levels();
		chk("revision", {20'h0, LOGIC_HW_REVISION}, {20'h0, orev});
		chk("logicware", {LW_MAJOR, LW_MINOR, LW_SUFFIX}, lwv);
		for (int k = 0; k < 8; k++)
		begin
			@(posedge clk);
			ff <= k[2:0];
			model <= 5'(k + 3);
			rot <= 4'(k + 5);
			dip <= 4'(k * 5);
			{six, flt} <= k[1:0];
			settle();
			chk("sensor fault", {23'h0, k == 1}, {23'h0, fs});
			chk("turn fault", {23'h0, k == 3}, {23'h0, fm});
			chk("config error", {23'h0, k > 3}, {23'h0, cerr});
			chk("rotary", {20'h0, 4'(k + 5)}, {20'h0, orot});
			chk("rotary range", {23'h0, k > 4}, {23'h0, rinv});
			chk("dip", {20'h0, ~4'(k * 5)}, {20'h0, odip});
			chk("six step", {23'h0, k[1]}, {23'h0, cmf});
			chk("healthy", {23'h0, ~k[0]}, {23'h0, ok});
		end
		$display("test levels done");
	endtask : test_levels
	task automatic test_enable();
		logic [3:0] st [5] = '{4'b1011, 4'b0010, 4'b1100, 4'b1111, 4'b0110};
		chk("soft at reset", 24'h1, {23'h0, spe});
		for (int k = 0; k < 5; k++)
		begin
			@(posedge clk);
			{hwen, swe, swd} <= st[k][3:1];
			@(posedge clk);
			swe <= 1'b0;
			settle();
			chk("power", {23'h0, st[k][0]}, {23'h0, pwr});
		end
		$display("test enable done");
	endtask : test_enable
	task automatic test_half_pwm();
		logic [7:0] c [8] = '{8'h35, 8'h36, 8'h20, 8'h1F, 8'h40, 8'h40, 8'h40, 8'h40};
		logic [15:0] f [8] = '{16'h64, 16'h121, 16'h64, 16'h64, 16'h64, 16'h1DD, 16'h1DE,
			16'h122};
		logic h [8] = '{1'b0, 1'b1, 1'b1, 1'b0, 1'b1, 1'b1, 1'b0, 1'b0};
		for (int k = 0; k < 8; k++)
		begin
			@(posedge clk);
			cur <= c[k];
			freq <= f[k];
			settle();
			chk("half pwm", {23'h0, h[k]}, {23'h0, half});
		end
		$display("test half pwm done");
	endtask : test_half_pwm
	task automatic complete_run();
		$display("checks %0d mismatches %0d", samples_checked, miscompares);
		if (miscompares == 0 && samples_checked > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : complete_run
	initial
	begin
		repeat (3) @(posedge clk);
		rst <= 1'b0;
		settle();
		chk("half at reset", 24'h0, {23'h0, half});
		test_enable();
		test_reads();
		test_levels();
		test_half_pwm();
		complete_run();
	end
endmodule : servo_drive_status_monitor_tb
